/* File: verilog/asia_core.v */
// alu, flags register, bank select and indirect access datapath
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "asia_consts.vh"
// What this block does
// - locations 00h and 02h redirect through pointers
// - indirect to indirect location reads zero, ignores write
// - pointer zero bank 0, pointer one uses bank
// - offsets below 40h always hit bank 0
// - pointers eight bits, bank select five/six bits
// - accumulator mapped at 05h, takes immediates
// - memory moves always pass through accumulator
// - eight bit alu with full operation set
// - alu updates flags besides writing result
// - bit 0 carry, no borrow, rotates through it
// - bit 1 nibble carry or no nibble borrow
// - bit 2 set when result is zero
// - overflow when carry in and out differ
// - bit 4 clear on reset/kick, set by halt
// - bit 5 clear reset/kick/halt, set by expiry
// - bits 6 and 7 read zero
// - status writes never touch bits 4, 5
// - arithmetic flags follow latest affecting operation
// - no automatic flag save on calls
// - bank 1bh offsets 40h-9fh hit display memory
module asia_core #(
  parameter NUM_BANKS = `ASIA_NUM_BANKS,
  parameter BANK_BITS = `ASIA_BANK_BITS
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] op_addr,
  input wire [7:0] op_imm,
  input wire op_use_imm,
  input wire op_to_mem,
  input wire halt_instr,
  input wire watchdog_kick_instr,
  input wire watchdog_expired,
  output reg op_skip,
  output wire [7:0] flags_out
);

  localparam RAM_DEPTH = NUM_BANKS * 192;
  localparam [5:0] BANK_MASK = 6'h3f >> (6 - BANK_BITS);
  // a narrow bank select drops its top bit on write, so a
  // small part can never name a bank above its own range

  // reset release through two flops
  // every flop below then leaves reset on one clean edge
  reg rst_meta_n;
  reg rst_sync_n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // architectural state
  reg [7:0] indirect_pointer_zero;
  reg [7:0] indirect_pointer_one;
  reg [5:0] ram_bank_select;
  reg [7:0] accumulator;
  reg carry_flag;
  reg nibble_flag;
  reg zero_flag;
  reg signed_wrap_flag;
  reg halted_flag;
  reg watchdog_expired_flag;
  // nothing here pushes the flags on a call or interrupt entry;
  // software saves and restores them itself when needed
  reg [7:0] gpr_mem [0:RAM_DEPTH-1];
  reg [7:0] lcd_mem [0:`ASIA_LCD_DEPTH-1];

  // only bits 0..5 exist, the top two read zero
  assign flags_out = {2'b00, watchdog_expired_flag, halted_flag,
                      signed_wrap_flag, zero_flag, nibble_flag,
                      carry_flag};

  // offsets below 40h stay in bank 0 for any bank value, so the
  // special registers look alike whichever bank is selected
  // map an address to {kind, index}; indirect via pointers
  function [13:0] resolve;
    input [7:0] addr;
    input [7:0] ptr0;
    input [7:0] ptr1;
    input [5:0] bank;
    reg ind;
    reg [7:0] off;
    reg [5:0] bk;
    reg [11:0] idx;
    begin
      ind = (addr == `ASIA_ADDR_IND0) || (addr == `ASIA_ADDR_IND1);
      off = (addr == `ASIA_ADDR_IND0) ? ptr0 :
            (addr == `ASIA_ADDR_IND1) ? ptr1 : addr;
      bk = (addr == `ASIA_ADDR_IND0) ? 6'h00 : bank;
      idx = {6'h00, bk} * `ASIA_BANK_SPAN + {4'h0, off} - 12'd64;
      if (ind && (off == `ASIA_ADDR_IND0 || off == `ASIA_ADDR_IND1))
        resolve = {`ASIA_KIND_NONE, 12'h000};
      else if (off < `ASIA_GPR_BASE)
        resolve = {`ASIA_KIND_SREG, 4'h0, off};
      else if (bk == `ASIA_LCD_BANK && off <= `ASIA_LCD_LAST)
        resolve = {`ASIA_KIND_LCD, 4'h0, off - `ASIA_GPR_BASE};
      else if ({26'h0, bk} < NUM_BANKS)
        resolve = {`ASIA_KIND_RAM, idx};
      else
        resolve = {`ASIA_KIND_NONE, 12'h000};
    end
  endfunction

  // read a resolved location
  function [7:0] fetch;
    input [13:0] loc;
    begin
      case (loc[13:12])
        `ASIA_KIND_RAM: fetch = gpr_mem[loc[11:0]];
        `ASIA_KIND_LCD: fetch = lcd_mem[loc[6:0]];
        `ASIA_KIND_SREG: begin
          case (loc[7:0])
            `ASIA_ADDR_PTR0: fetch = indirect_pointer_zero;
            `ASIA_ADDR_PTR1: fetch = indirect_pointer_one;
            `ASIA_ADDR_BANK: fetch = {2'b00, ram_bank_select};
            `ASIA_ADDR_ACC: fetch = accumulator;
            `ASIA_ADDR_FLAGS: fetch = flags_out;
            default: fetch = 8'h00;
          endcase
        end
        default: fetch = 8'h00;
      endcase
    end
  endfunction

  // address resolution for both access paths
  wire [13:0] reg_loc;
  wire [13:0] op_loc;
  assign reg_loc = resolve(reg_addr, indirect_pointer_zero,
                           indirect_pointer_one, ram_bank_select);
  assign op_loc = resolve(op_addr, indirect_pointer_zero,
                          indirect_pointer_one, ram_bank_select);

  // operand: immediate or one memory location, never two
  wire [7:0] mem_val;
  wire [7:0] opnd;
  assign mem_val = fetch(op_loc);
  assign opnd = op_use_imm ? op_imm : mem_val;

  // alu evaluation
  reg [7:0] next_res;
  reg next_c;
  reg next_ac;
  reg next_ov;
  reg upd_arith;
  reg upd_c;
  reg upd_z;
  reg wr_res;
  reg next_skip;
  reg [7:0] addend;
  reg cin;
  reg [4:0] lo_sum;
  reg [7:0] low7;
  reg [8:0] sum9;
  reg [8:0] daa9;
  always @* begin
    next_res = 8'h00;
    next_c = carry_flag;
    next_ac = nibble_flag;
    next_ov = signed_wrap_flag;
    upd_arith = 1'b0;
    upd_c = 1'b0;
    upd_z = 1'b0;
    wr_res = 1'b1;
    next_skip = 1'b0;
    addend = opnd;
    cin = 1'b0;
    daa9 = 9'h000;
    // one adder serves add and subtract; subtract adds ~b + 1
    // so the carry out reads directly as the no-borrow flag
    case (op_code)
      `ASIA_OP_ADC: cin = carry_flag;
      `ASIA_OP_SUB: begin
        addend = ~opnd;
        cin = 1'b1;
      end
      `ASIA_OP_SBC: begin
        addend = ~opnd;
        cin = carry_flag;
      end
      default: cin = 1'b0;
    endcase
    lo_sum = {1'b0, accumulator[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    low7 = {1'b0, accumulator[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
    sum9 = {1'b0, accumulator} + {1'b0, addend} + {8'h00, cin};
    case (op_code)
      `ASIA_OP_ADD, `ASIA_OP_ADC, `ASIA_OP_SUB, `ASIA_OP_SBC: begin
        next_res = sum9[7:0];
        next_c = sum9[8];
        next_ac = lo_sum[4];
        next_ov = low7[7] ^ sum9[8];
        upd_arith = 1'b1;
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      `ASIA_OP_DAA: begin
        daa9 = {1'b0, accumulator};
        if (accumulator[3:0] > 4'h9 || nibble_flag)
          daa9 = daa9 + 9'h006;
        if (daa9[7:4] > 4'h9 || carry_flag || daa9[8])
          daa9 = daa9 + 9'h060;
        next_res = daa9[7:0];
        next_c = carry_flag | daa9[8];
        upd_c = 1'b1;
      end
      `ASIA_OP_AND: begin
        next_res = accumulator & opnd;
        upd_z = 1'b1;
      end
      `ASIA_OP_OR: begin
        next_res = accumulator | opnd;
        upd_z = 1'b1;
      end
      `ASIA_OP_XOR: begin
        next_res = accumulator ^ opnd;
        upd_z = 1'b1;
      end
      `ASIA_OP_CPL: begin
        next_res = ~opnd;
        upd_z = 1'b1;
      end
      `ASIA_OP_RL: next_res = {opnd[6:0], opnd[7]};
      `ASIA_OP_RR: next_res = {opnd[0], opnd[7:1]};
      `ASIA_OP_RLC: begin
        next_res = {opnd[6:0], carry_flag};
        next_c = opnd[7];
        upd_c = 1'b1;
      end
      `ASIA_OP_RRC: begin
        next_res = {carry_flag, opnd[7:1]};
        next_c = opnd[0];
        upd_c = 1'b1;
      end
      `ASIA_OP_INC: begin
        next_res = opnd + 8'h01;
        upd_z = 1'b1;
      end
      `ASIA_OP_DEC: begin
        next_res = opnd - 8'h01;
        upd_z = 1'b1;
      end
      `ASIA_OP_SZ: begin
        wr_res = 1'b0;
        next_skip = (opnd == 8'h00);
      end
      `ASIA_OP_SNZ: begin
        wr_res = 1'b0;
        next_skip = (opnd != 8'h00);
      end
      `ASIA_OP_SIZ: begin
        next_res = opnd + 8'h01;
        next_skip = (next_res == 8'h00);
      end
      `ASIA_OP_SDZ: begin
        next_res = opnd - 8'h01;
        next_skip = (next_res == 8'h00);
      end
      `ASIA_OP_LDA: next_res = opnd;
      `ASIA_OP_STA: next_res = accumulator;
      default: wr_res = 1'b0;
    endcase
  end

  // single memory write port: an operation beats the register port
  // a register write lost in such a cycle is the price of one port
  wire op_go;
  wire op_mem_wr;
  wire op_acc_wr;
  wire [13:0] wr_loc;
  wire [7:0] wr_data;
  wire wr_en;
  assign op_go = ce && op_valid;
  assign op_mem_wr = op_go && wr_res &&
                     (op_to_mem || op_code == `ASIA_OP_STA);
  assign op_acc_wr = op_go && wr_res && !op_mem_wr;
  assign wr_loc = op_mem_wr ? op_loc : reg_loc;
  assign wr_data = op_mem_wr ? next_res : reg_wdata;
  assign wr_en = ce && (op_mem_wr || reg_wr);

  // storage arrays hold no reset
  // software must write a location before it reads it back
  always @(posedge clk) begin
    if (wr_en && wr_loc[13:12] == `ASIA_KIND_RAM)
      gpr_mem[wr_loc[11:0]] <= wr_data;
    if (wr_en && wr_loc[13:12] == `ASIA_KIND_LCD)
      lcd_mem[wr_loc[6:0]] <= wr_data;
  end

  // special register write decode
  wire sreg_wr;
  assign sreg_wr = wr_en && wr_loc[13:12] == `ASIA_KIND_SREG;

  // pointers, bank select, accumulator and flags
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      indirect_pointer_zero <= `ASIA_RST_PTR;
      indirect_pointer_one <= `ASIA_RST_PTR;
      ram_bank_select <= `ASIA_RST_BANK;
      accumulator <= `ASIA_RST_ACC;
      carry_flag <= 1'b0;
      nibble_flag <= 1'b0;
      zero_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      halted_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      op_skip <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      // skip result stands for one cycle only
      op_skip <= op_valid && next_skip;
      if (reg_rd)
        reg_rdata <= fetch(reg_loc);
      if (sreg_wr) begin
        case (wr_loc[7:0])
          `ASIA_ADDR_PTR0: indirect_pointer_zero <= wr_data;
          `ASIA_ADDR_PTR1: indirect_pointer_one <= wr_data;
          `ASIA_ADDR_BANK: ram_bank_select <= wr_data[5:0] & BANK_MASK;
          `ASIA_ADDR_ACC: accumulator <= wr_data;
          `ASIA_ADDR_FLAGS: begin
            // time-out and power-down bits are not writable
            carry_flag <= wr_data[`ASIA_FLAG_C];
            nibble_flag <= wr_data[`ASIA_FLAG_AC];
            zero_flag <= wr_data[`ASIA_FLAG_Z];
            signed_wrap_flag <= wr_data[`ASIA_FLAG_OV];
          end
          default: ;
        endcase
      end
      if (op_acc_wr)
        accumulator <= next_res;
      // alu flags override a same-cycle data write of the flags
      if (op_go && upd_c)
        carry_flag <= next_c;
      if (op_go && upd_arith) begin
        nibble_flag <= next_ac;
        signed_wrap_flag <= next_ov;
      end
      if (op_go && upd_z)
        zero_flag <= (next_res == 8'h00);
      // a halt beats a kick that falls in the same cycle
      // power-down: halt sets, kick clears
      if (halt_instr)
        halted_flag <= 1'b1;
      else if (watchdog_kick_instr)
        halted_flag <= 1'b0;
      // expiry wins over a clear in the same cycle
      if (watchdog_expired)
        watchdog_expired_flag <= 1'b1;
      else if (halt_instr || watchdog_kick_instr)
        watchdog_expired_flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/asia_consts.vh */
// constants for the alu, status and indirect access datapath slice
`ifndef ASIA_CONSTS_VH
`define ASIA_CONSTS_VH

// data memory offsets of the mapped registers
`define ASIA_ADDR_IND0 8'h00
`define ASIA_ADDR_PTR0 8'h01
`define ASIA_ADDR_IND1 8'h02
`define ASIA_ADDR_PTR1 8'h03
`define ASIA_ADDR_BANK 8'h04
`define ASIA_ADDR_ACC 8'h05
`define ASIA_ADDR_FLAGS 8'h0a

// memory map layout
`define ASIA_GPR_BASE 8'h40
`define ASIA_LCD_LAST 8'h9f
`define ASIA_LCD_BANK 6'h1b
`define ASIA_BANK_SPAN 12'd192
`define ASIA_LCD_DEPTH 96
`define ASIA_NUM_BANKS 15
`define ASIA_BANK_BITS 6

// resolved access kinds
`define ASIA_KIND_NONE 2'd0
`define ASIA_KIND_SREG 2'd1
`define ASIA_KIND_RAM 2'd2
`define ASIA_KIND_LCD 2'd3

// flag bit positions
`define ASIA_FLAG_C 0
`define ASIA_FLAG_AC 1
`define ASIA_FLAG_Z 2
`define ASIA_FLAG_OV 3
`define ASIA_FLAG_PD 4
`define ASIA_FLAG_TO 5

// reset values
`define ASIA_RST_PTR 8'h00
`define ASIA_RST_BANK 6'h00
`define ASIA_RST_ACC 8'h00

// operation codes from the sequencer
`define ASIA_OP_ADD 5'h00
`define ASIA_OP_ADC 5'h01
`define ASIA_OP_SUB 5'h02
`define ASIA_OP_SBC 5'h03
`define ASIA_OP_DAA 5'h04
`define ASIA_OP_AND 5'h05
`define ASIA_OP_OR 5'h06
`define ASIA_OP_XOR 5'h07
`define ASIA_OP_CPL 5'h08
`define ASIA_OP_RL 5'h09
`define ASIA_OP_RR 5'h0a
`define ASIA_OP_RLC 5'h0b
`define ASIA_OP_RRC 5'h0c
`define ASIA_OP_INC 5'h0d
`define ASIA_OP_DEC 5'h0e
`define ASIA_OP_SZ 5'h0f
`define ASIA_OP_SNZ 5'h10
`define ASIA_OP_SIZ 5'h11
`define ASIA_OP_SDZ 5'h12
`define ASIA_OP_LDA 5'h13
`define ASIA_OP_STA 5'h14

`endif

/* File: verification/asia_core_props.sv */
// concurrent checks on the ports of the alu and flags datapath slice
`timescale 1ns/1ps
`default_nettype none
`include "asia_consts.vh"
module asia_core_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] op_addr,
  input wire logic [7:0] op_imm,
  input wire logic op_use_imm,
  input wire logic op_to_mem,
  input wire logic halt_instr,
  input wire logic watchdog_kick_instr,
  input wire logic watchdog_expired,
  input wire logic op_skip,
  input wire logic [7:0] flags_out
);
  default clocking cb @(posedge clk); endclocking
  // one stage longer than the internal reset release: checks start
  // one edge after the edge at which the design leaves reset
  logic [2:0] rst_pipe = 3'b000;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 3'b000;
    end else begin
      rst_pipe <= {rst_pipe[1:0], 1'b1};
    end
  end
  default disable iff (!rst_pipe[2]);
  // power and watchdog flag behaviour
  a_high_zero: assert property (flags_out[7:6] == 2'b00)
    else $error("flag bits 7 and 6 not zero");
  a_halt_sets: assert property (ce && halt_instr && !watchdog_expired
    |=> flags_out[5:4] == 2'b01) else $error("halt did not set bit 4");
  a_kick_clears: assert property (ce && watchdog_kick_instr &&
    !halt_instr && !watchdog_expired |=> flags_out[5:4] == 2'b00)
    else $error("kick did not clear bits 5 and 4");
  a_expiry_sets: assert property (ce && watchdog_expired
    |=> flags_out[5]) else $error("expiry did not set bit 5");
  a_pd_holds: assert property (ce && !halt_instr &&
    !watchdog_kick_instr |=> $stable(flags_out[4]))
    else $error("bit 4 changed without cause");
  a_to_holds: assert property (ce && !watchdog_expired &&
    !halt_instr && !watchdog_kick_instr |=> $stable(flags_out[5]))
    else $error("bit 5 changed without cause");
  // register port and alu relations
  a_acc_readback: assert property (ce && reg_wr && !op_valid &&
    reg_addr == `ASIA_ADDR_ACC ##1 reg_rd && !reg_wr && !op_valid &&
    reg_addr == `ASIA_ADDR_ACC |=> reg_rdata == $past(reg_wdata, 2))
    else $error("accumulator read back wrong");
  a_self_ind: assert property (ce && reg_wr &&
    reg_addr == `ASIA_ADDR_PTR0 && reg_wdata == `ASIA_ADDR_IND1 ##1
    reg_rd && reg_addr == `ASIA_ADDR_IND0 |=> reg_rdata == 8'h00)
    else $error("indirect to indirect read not zero");
  a_and_zero: assert property (ce && op_valid && op_use_imm &&
    op_code == `ASIA_OP_AND && op_imm == 8'h00 |=> flags_out[2])
    else $error("zero result left bit 2 clear");
  a_skip_zero: assert property (ce && op_valid && op_use_imm &&
    op_code == `ASIA_OP_SZ && op_imm == 8'h00 |=> op_skip)
    else $error("skip on zero missing");
  c_skip: cover property (op_skip);
  c_both_flags: cover property (flags_out[5:4] == 2'b11);
  c_ind_read: cover property (reg_rd && reg_addr == `ASIA_ADDR_IND0);
endmodule
`default_nettype wire

/* File: verification/asia_core_tb.sv */
// self-checking bench for the alu and flags datapath slice
`timescale 1ns/1ps
`default_nettype none
`include "asia_consts.vh"
module asia_core_tb;
  typedef struct packed {
    logic [7:0] a; logic [4:0] c; logic [7:0] i;
    logic [3:0] p; logic [7:0] r; logic [3:0] f;
  } asia_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0;
  logic op_use_imm = 1'b1, op_to_mem = 1'b0;
  logic halt_instr = 1'b0, watchdog_kick_instr = 1'b0;
  logic watchdog_expired = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] op_addr = 8'h00, op_imm = 8'h00;
  logic [4:0] op_code = 5'h00;
  wire [7:0] reg_rdata;
  wire [7:0] flags_out;
  wire op_skip;
  int failures = 0;
  int compares = 0;
  int n;
  logic [7:0] d;
  asia_row_t rows [0:18];
  asia_core #(.NUM_BANKS(15), .BANK_BITS(6)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_imm(op_imm), .op_use_imm(op_use_imm),
    .op_to_mem(op_to_mem), .halt_instr(halt_instr),
    .watchdog_kick_instr(watchdog_kick_instr),
    .watchdog_expired(watchdog_expired), .op_skip(op_skip),
    .flags_out(flags_out));
  // free running clock
  always #5 clk = ~clk;
  // one cycle of every pulse input, then wait for the edge
  task put(input logic w, r, v, input logic [2:0] m,
           input logic [7:0] a, dv, input logic [4:0] c);
    reg_wr <= w;
    reg_rd <= r;
    op_valid <= v;
    {halt_instr, watchdog_kick_instr, watchdog_expired} <= m;
    reg_addr <= a;
    op_addr <= a;
    reg_wdata <= dv;
    op_imm <= dv;
    op_code <= c;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, dv);
    put(1'b1, 1'b0, 1'b0, 3'b000, a, dv, 5'h00);
  endtask
  // read strobe, then idle cycle in which the data stand
  task rd(input logic [7:0] a, output logic [7:0] q);
    put(1'b0, 1'b1, 1'b0, 3'b000, a, 8'h00, 5'h00);
    put(1'b0, 1'b0, 1'b0, 3'b000, a, 8'h00, 5'h00);
    q = reg_rdata;
  endtask
  task op(input logic [4:0] c, input logic [7:0] i);
    put(1'b0, 1'b0, 1'b1, 3'b000, 8'h00, i, c);
  endtask
  // one quiet cycle; outputs launched before it are read after it
  task idle;
    put(1'b0, 1'b0, 1'b0, 3'b000, 8'h00, 8'h00, 5'h00);
  endtask
  task pin(input logic [2:0] m);
    put(1'b0, 1'b0, 1'b0, m, 8'h00, 8'h00, 5'h00);
    idle;
  endtask
  task chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #50000;
    failures++;
    print_verdict;
  end
  // main sequence
  initial begin
    rows = '{'{8'hff, `ASIA_OP_ADD, 8'h01, 4'h0, 8'h00, 4'h7},
      '{8'h7f, `ASIA_OP_ADD, 8'h01, 4'h0, 8'h80, 4'ha},
      '{8'h80, `ASIA_OP_ADD, 8'h80, 4'h0, 8'h00, 4'hd},
      '{8'h00, `ASIA_OP_ADC, 8'h00, 4'h1, 8'h01, 4'h0},
      '{8'h05, `ASIA_OP_SUB, 8'h05, 4'h0, 8'h00, 4'h7},
      '{8'h00, `ASIA_OP_SUB, 8'h01, 4'hf, 8'hff, 4'h0},
      '{8'h05, `ASIA_OP_SBC, 8'h02, 4'h0, 8'h02, 4'h3},
      '{8'h0a, `ASIA_OP_DAA, 8'h00, 4'h6, 8'h10, 4'h6},
      '{8'hff, `ASIA_OP_AND, 8'h00, 4'hb, 8'h00, 4'hf},
      '{8'h10, `ASIA_OP_OR, 8'h01, 4'h4, 8'h11, 4'h0},
      '{8'h5a, `ASIA_OP_XOR, 8'h5a, 4'h0, 8'h00, 4'h4},
      '{8'h00, `ASIA_OP_CPL, 8'hff, 4'h0, 8'h00, 4'h4},
      '{8'h00, `ASIA_OP_RL, 8'h81, 4'h5, 8'h03, 4'h5},
      '{8'h00, `ASIA_OP_RR, 8'h81, 4'ha, 8'hc0, 4'ha},
      '{8'h00, `ASIA_OP_RLC, 8'h80, 4'h0, 8'h00, 4'h1},
      '{8'h00, `ASIA_OP_RRC, 8'h02, 4'h1, 8'h81, 4'h0},
      '{8'h00, `ASIA_OP_INC, 8'hff, 4'h1, 8'h00, 4'h5},
      '{8'h00, `ASIA_OP_DEC, 8'h01, 4'h0, 8'h00, 4'h4},
      '{8'h00, `ASIA_OP_LDA, 8'h3c, 4'h0, 8'h3c, 4'h0}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 19; n++) begin
      wr(`ASIA_ADDR_ACC, rows[n].a);
      wr(`ASIA_ADDR_FLAGS, {4'h0, rows[n].p});
      op(rows[n].c, rows[n].i);
      rd(`ASIA_ADDR_ACC, d);
      chk("acc", rows[n].r, d);
      chk("flags", {4'h0, rows[n].f}, {4'h0, flags_out[3:0]});
    end
    $display("alu table done");
    // indirect access through both pointers
    wr(8'h04, 8'h00);
    wr(8'h42, 8'h11);
    wr(8'h04, 8'h01);
    wr(8'h03, 8'h42);
    wr(8'h02, 8'h88);
    rd(8'h42, d);
    chk("ind1", 8'h88, d);
    wr(8'h01, 8'h42);
    rd(8'h00, d);
    chk("ind0", 8'h11, d);
    wr(8'h00, 8'h66);
    wr(8'h03, 8'h05);
    wr(8'h02, 8'h5a);
    rd(8'h05, d);
    chk("common", 8'h5a, d);
    wr(8'h01, 8'h02);
    rd(8'h00, d);
    chk("self", 8'h00, d);
    wr(8'h04, 8'h00);
    rd(8'h42, d);
    chk("ind0wr", 8'h66, d);
    $display("indirect done");
    // display bank, missing banks, bank width, accumulator
    wr(8'h04, 8'h1b);
    wr(8'h40, 8'ha5);
    wr(8'ha0, 8'h77);
    wr(8'h04, 8'h00);
    wr(8'h40, 8'h3c);
    wr(8'h04, 8'h1b);
    rd(8'h40, d);
    chk("lcd", 8'ha5, d);
    rd(8'ha0, d);
    chk("lcdtop", 8'h00, d);
    wr(8'h04, 8'h0f);
    wr(8'h40, 8'h99);
    rd(8'h40, d);
    chk("nobank", 8'h00, d);
    wr(8'h04, 8'hff);
    rd(8'h04, d);
    chk("bank", 8'h3f, d);
    rd(8'h06, d);
    chk("unmapped", 8'h00, d);
    wr(8'h05, 8'hc3);
    rd(8'h05, d);
    chk("acc", 8'hc3, d);
    $display("banks done");
    // skip decisions
    op(`ASIA_OP_SZ, 8'h00);
    idle;
    chk("skip", 8'h01, {7'h00, op_skip});
    op(`ASIA_OP_SNZ, 8'h00);
    idle;
    chk("skip", 8'h00, {7'h00, op_skip});
    op(`ASIA_OP_SIZ, 8'hff);
    idle;
    chk("skip", 8'h01, {7'h00, op_skip});
    op(`ASIA_OP_SDZ, 8'h05);
    idle;
    chk("skip", 8'h00, {7'h00, op_skip});
    // store the accumulator to memory, then a write while frozen
    wr(`ASIA_ADDR_BANK, 8'h00);
    put(1'b0, 1'b0, 1'b1, 3'b000, 8'h41, 8'h00, `ASIA_OP_STA);
    rd(8'h41, d);
    chk("sta", 8'h04, d);
    ce <= 1'b0;
    wr(`ASIA_ADDR_ACC, 8'h11);
    ce <= 1'b1;
    rd(`ASIA_ADDR_ACC, d);
    chk("frozen", 8'h04, d);
    $display("skip done");
    // status writes, halt, kick, expiry
    wr(`ASIA_ADDR_FLAGS, 8'hff);
    rd(`ASIA_ADDR_FLAGS, d);
    chk("status", 8'h0f, d);
    pin(3'b100);
    chk("halt", 8'h10, flags_out & 8'h30);
    pin(3'b001);
    chk("expire", 8'h30, flags_out & 8'h30);
    wr(`ASIA_ADDR_FLAGS, 8'h00);
    idle;
    chk("wrflags", 8'h30, flags_out);
    pin(3'b010);
    chk("kick", 8'h00, flags_out & 8'h30);
    pin(3'b001);
    pin(3'b100);
    chk("halt2", 8'h10, flags_out & 8'h30);
    pin(3'b001);
    $display("status done");
    // reset in mid-run clears flags and registers
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rstflags", 8'h00, flags_out);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h05, d);
    chk("rstacc", 8'h00, d);
    rd(8'h04, d);
    chk("rstbank", 8'h00, d);
    $display("reset done");
    print_verdict;
  end
endmodule
bind asia_core asia_core_props u_props (
  .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
  .op_addr(op_addr), .op_imm(op_imm), .op_use_imm(op_use_imm),
  .op_to_mem(op_to_mem), .halt_instr(halt_instr),
  .watchdog_kick_instr(watchdog_kick_instr),
  .watchdog_expired(watchdog_expired), .op_skip(op_skip),
  .flags_out(flags_out));
`default_nettype wire
